//--- core/dsd_pkg.sv
/*
 package for the sector transfer link between the host-side transfer logic and the
 disk-side controller. assumes one 200 MHz clock and a synchronous active-high reset.
*/
package dsd_pkg;
   // ----------------------------------------
   // sector and silo geometry
   // ----------------------------------------
   localparam int SECTOR_WORDS = 256;
   localparam int SILO_WORDS = 128;
   localparam int SILO_CYL_IDX = 118;
   localparam int SILO_TRK_IDX = 119;
   localparam int SILO_SEC_IDX = 120;
   localparam int ECC_BITS = 32;
   localparam int BURST_MAX = 11;
   localparam int RTH_WORDS = 4;
   // ----------------------------------------
   // control status register fields
   // ----------------------------------------
   localparam int CSR_RDY_BIT = 7;
   localparam int CSR_IE_BIT = 6;
   localparam int CSR_ERR_BIT = 15;
   localparam int CSR_FN_LSB = 1;
   localparam logic [15:0] CSR_RESET = 16'h0080;
   localparam logic [8:0] INT_VECTOR = 9'h070;
   localparam logic [2:0] INT_LEVEL = 3'h5;
   localparam logic [15:0] RTH_MARK = 16'h00B4;
   localparam logic [31:0] ECC_POLY = 32'hA0000805;
   // ----------------------------------------
   // functions
   // ----------------------------------------
   typedef enum logic [2:0]
   {
      FN_MULTI = 3'h0, FN_WCHECK = 3'h1, FN_STATUS = 3'h2, FN_SEEK = 3'h3,
      FN_RDHDR = 3'h4, FN_WRITE = 3'h5, FN_READ = 3'h6, FN_READNH = 3'h7
   } dsd_fn_t;
endpackage

//--- core/dsd_link_if.sv
/*
 link between host-side transfer logic and disk-side controller.
 assumes both ends share clk_sys.
*/
`timescale 1ns/10ps
interface dsd_link_if;
   logic [15:0] regWdata;
   logic [1:0] regAddr;
   logic regWr;
   logic regRd;
   logic [15:0] regRdata;
   logic irqReq;
   logic [8:0] irqVector;
   logic [2:0] irqLevel;
   logic dmaReq;
   logic dmaWrite;
   logic [15:0] dmaAddr;
   logic [15:0] dmaWdata;
   logic dmaAck;
   logic [15:0] dmaRdata;
   modport device (input regWdata, regAddr, regWr, regRd, dmaAck, dmaRdata,
      output regRdata, irqReq, irqVector, irqLevel, dmaReq, dmaWrite, dmaAddr, dmaWdata);
   modport host (output regWdata, regAddr, regWr, regRd, dmaAck, dmaRdata,
      input regRdata, irqReq, irqVector, irqLevel, dmaReq, dmaWrite, dmaAddr, dmaWdata);
endinterface // dsd_link_if

//--- core/dsd_fifo.sv
/*
 sector buffer fifo, valid/ready on both sides.
 assumes one clock, synchronous reset.
*/
`timescale 1ns/10ps
module dsd_fifo #(parameter int WIDTH = 16, parameter int DEPTH = 8)
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed
   {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } dsd_fifo_st_t;
   dsd_fifo_st_t s_q, s_d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic full;
   logic empty;
   assign full = (s_q.wp[AW] != s_q.rp[AW]) && (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
   assign empty = s_q.wp == s_q.rp;
   assign inReady = !full;
   assign outValid = !empty;
   assign outData = mem[s_q.rp[AW-1:0]];
   always_comb
   begin
      s_d = s_q;
      if (inValid && !full)
      begin
         s_d.wp = s_q.wp + 1'b1;
      end
      if (outReady && !empty)
      begin
         s_d.rp = s_q.rp + 1'b1;
      end
   end
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
      if (inValid && !full)
      begin
         mem[s_q.wp[AW-1:0]] <= inData;
      end
   end
endmodule // dsd_fifo

//--- core/dsd_device.sv
/*
 disk-side controller: csr, interrupt request, dma, sector buffer, ecc, silo readout.
 assumes the host end of dsd_link_if and a simple word-wide drive data port.
*/
// What this block does
// - data field always 256 words
// - short write pads field with zeros
// - 32-bit ecc written, checked on read
// - correct single burst up to 11 bits; code XORs diskBurstMask into the one word at diskBurstIdx
// - replacement header repeated across bad track
// - header: cylinder, track upper bits, two checks
// - substitute track copies original headers exactly
// - read header returns logical address in silo word 0
// - multipurpose code 0 loads registers into silo
// - silo 118-120 hold next physical address
// - interrupt when enable and ready set
// - software sets enable; initialize clears it
// - ready set on done, error, initialize
// - vector 160, bus level 5
// - seek: ready and interrupt at once
// - software writes seek difference word first
// - read fills sector before dma out
// - write fetches full sector before disk
// - software loads address, disk, count, command
// - function 7 runs as a plain read, ecc error still flagged
// - correct only on alternate retry attempts
// - never correct during write check
`timescale 1ns/10ps
module dsd_device #(parameter int FIFO_DEPTH = 8)
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   dsd_link_if.device link,
   input wire logic [15:0] logCylTrk,
   input wire logic [15:0] physCyl,
   input wire logic [15:0] physTrk,
   input wire logic [15:0] physSec,
   input wire logic diskValid,
   input wire logic [15:0] diskRdata,
   input wire logic diskEccBad,
   input wire logic [15:0] diskBurstMask,
   input wire logic [7:0] diskBurstIdx,
   output logic diskReadReq,
   output logic diskWriteStb,
   output logic [15:0] diskWdata,
   output logic [31:0] eccOut,
   output logic replaceStb,
   output logic [15:0] replaceWord,
   input wire logic replaceTrack,
   input wire logic driveReady
);
   typedef enum logic [2:0] {S_IDLE, S_FETCH, S_DISKW, S_DISKR, S_DMAOUT, S_DONE} dsd_st_t;
   typedef struct packed
   {
      dsd_st_t st;
      logic [15:0] control_status_register;
      logic [15:0] ba;
      logic [15:0] da;
      logic [15:0] wc;
      logic [8:0] ptr;
      logic [31:0] ecc;
      logic [6:0] siloPtr;
      logic attemptOdd;
      logic [1:0] rthIdx;
      logic dWr;
      logic [15:0] dWdata;
      logic dReq;
   } dsd_dev_t;
   dsd_dev_t s_q, s_d;
   logic [15:0] buffer [dsd_pkg::SECTOR_WORDS];
   logic [15:0] silo [dsd_pkg::SILO_WORDS];
   logic [15:0] bufRd;
   logic bufWe;
   logic [15:0] bufWdata;
   logic [15:0] fifoOut;
   logic fifoValid;
   logic fifoInReady;
   logic fifoPush;
   logic fifoPop;
   logic siloLoad;
   logic [2:0] fn;
   logic [31:0] eccNext;
   logic [15:0] fixMask;
   assign fn = s_q.control_status_register[dsd_pkg::CSR_FN_LSB +: 3];
   assign bufRd = buffer[s_q.ptr[7:0]];
   // ----------------------------------------
   // ecc: shift each word into a 32-bit lfsr
   // ----------------------------------------
   function automatic logic [31:0] eccStep(input logic [31:0] c, input logic [15:0] w);
      logic [31:0] r;
      r = c;
      for (int i = 15; i >= 0; i--)
      begin
         r = {r[30:0], 1'b0} ^ ((r[31] ^ w[i]) ? dsd_pkg::ECC_POLY : 32'h00000000);
      end
      return r;
   endfunction
   assign eccNext = eccStep(s_q.ecc, s_q.dWdata);
   // fifo decouples the dma side from the buffer so host stalls only back up the fetch
   dsd_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .inValid(fifoPush),
      .inReady(fifoInReady),
      .inData(link.dmaRdata),
      .outValid(fifoValid),
      .outReady(fifoPop),
      .outData(fifoOut)
   );
   assign fifoPush = s_q.st == S_FETCH && link.dmaAck && !link.dmaWrite;
   assign link.dmaReq = (s_q.st == S_FETCH && fifoInReady && s_q.wc != 16'h0000)
      || (s_q.st == S_DMAOUT && s_q.wc != 16'h0000);
   assign link.dmaWrite = s_q.st == S_DMAOUT;
   assign link.dmaAddr = s_q.ba;
   assign link.dmaWdata = bufRd;
   assign link.irqReq = s_q.control_status_register[dsd_pkg::CSR_IE_BIT] && s_q.control_status_register[dsd_pkg::CSR_RDY_BIT];
   assign link.irqVector = dsd_pkg::INT_VECTOR;
   assign link.irqLevel = dsd_pkg::INT_LEVEL;
   assign diskWriteStb = s_q.dWr;
   assign diskWdata = s_q.dWdata;
   assign diskReadReq = s_q.dReq;
   assign eccOut = s_q.ecc;
   // replacement header: cylinder, track in upper byte plus mark, two check words
   always_comb
   begin
      case (s_q.rthIdx)
         2'h0: replaceWord = physCyl;
         2'h1: replaceWord = {physTrk[7:0], dsd_pkg::RTH_MARK[7:0]};
         2'h2: replaceWord = s_q.ecc[31:16];
         default: replaceWord = s_q.ecc[15:0];
      endcase
   end
   assign replaceStb = replaceTrack && s_q.st == S_IDLE;
   // burst correction applied only on alternate attempts and never on write check
   assign fixMask = (diskEccBad && s_q.attemptOdd && fn != dsd_pkg::FN_WCHECK) ? diskBurstMask
      : 16'h0000;
   always_comb
   begin
      s_d = s_q;
      bufWe = 1'b0;
      bufWdata = 16'h0000;
      fifoPop = 1'b0;
      siloLoad = 1'b0;
      s_d.dWr = 1'b0;
      link.regRdata = 16'h0000;
      case (link.regAddr)
         // drive ready sits at bit 8 so it never masks the controller ready flag
         2'h0: link.regRdata = s_q.control_status_register | {7'h00, driveReady, 8'h00};
         2'h1: link.regRdata = s_q.ba;
         2'h2: link.regRdata = s_q.da;
         default: link.regRdata = silo[s_q.siloPtr];
      endcase
      if (link.regRd && link.regAddr == 2'h3)
      begin
         s_d.siloPtr = s_q.siloPtr + 7'h01;
      end
      if (replaceStb)
      begin
         s_d.rthIdx = s_q.rthIdx + 2'h1;
      end
      if (link.regWr)
      begin
         case (link.regAddr)
            2'h0: s_d.control_status_register = {s_q.control_status_register[15:8], link.regWdata[7:0]};
            2'h1: s_d.ba = link.regWdata;
            2'h2: s_d.da = link.regWdata;
            default: s_d.wc = link.regWdata;
         endcase
      end
      case (s_q.st)
         S_IDLE:
         begin
            if (!s_q.control_status_register[dsd_pkg::CSR_RDY_BIT])
            begin
               s_d.ptr = 9'h000;
               s_d.ecc = 32'h00000000;
               case (fn)
                  dsd_pkg::FN_MULTI:
                  begin
                     siloLoad = 1'b1;
                     s_d.siloPtr = 7'h00;
                     s_d.st = S_DONE;
                  end
                  dsd_pkg::FN_SEEK: s_d.st = S_DONE;
                  dsd_pkg::FN_RDHDR:
                  begin
                     s_d.siloPtr = 7'h00;
                     siloLoad = 1'b1;
                     s_d.st = S_DONE;
                  end
                  dsd_pkg::FN_WRITE: s_d.st = S_FETCH;
                  default:
                  begin
                     s_d.dReq = 1'b1;
                     s_d.st = S_DISKR;
                  end
               endcase
            end
         end
         S_FETCH:
         begin
            if (fifoPush)
            begin
               s_d.ba = s_q.ba + 16'h0002;
               s_d.wc = s_q.wc + 16'h0001;
            end
            if (fifoValid)
            begin
               fifoPop = 1'b1;
               bufWe = 1'b1;
               bufWdata = fifoOut;
               s_d.ptr = s_q.ptr + 9'h001;
            end
            else if (s_q.wc == 16'h0000)
            begin
               bufWe = s_q.ptr != 9'(dsd_pkg::SECTOR_WORDS);
               bufWdata = 16'h0000;
               s_d.ptr = bufWe ? s_q.ptr + 9'h001 : 9'h000;
               if (!bufWe)
               begin
                  s_d.st = S_DISKW;
               end
            end
         end
         S_DISKW:
         begin
            s_d.dWr = s_q.ptr != 9'(dsd_pkg::SECTOR_WORDS);
            s_d.dWdata = bufRd;
            if (s_q.dWr)
            begin
               s_d.ecc = eccNext;
            end
            if (s_q.ptr == 9'(dsd_pkg::SECTOR_WORDS))
            begin
               s_d.st = s_q.dWr ? S_DISKW : S_DONE;
            end
            else
            begin
               s_d.ptr = s_q.ptr + 9'h001;
            end
         end
         S_DISKR:
         begin
            s_d.dReq = 1'b0;
            if (diskValid)
            begin
               bufWe = 1'b1;
               bufWdata = diskRdata ^ ((s_q.ptr[7:0] == diskBurstIdx) ? fixMask : 16'h0000);
               s_d.ptr = s_q.ptr + 9'h001;
               if (s_q.ptr == 9'(dsd_pkg::SECTOR_WORDS - 1))
               begin
                  s_d.ptr = 9'h000;
                  s_d.attemptOdd = !s_q.attemptOdd;
                  s_d.control_status_register[dsd_pkg::CSR_ERR_BIT] = diskEccBad && fixMask == 16'h0000;
                  s_d.st = fn == dsd_pkg::FN_WCHECK ? S_DONE : S_DMAOUT;
               end
            end
         end
         S_DMAOUT:
         begin
            if (link.dmaAck)
            begin
               s_d.ba = s_q.ba + 16'h0002;
               s_d.wc = s_q.wc + 16'h0001;
               s_d.ptr = s_q.ptr + 9'h001;
            end
            if (s_q.wc == 16'h0000)
            begin
               s_d.st = S_DONE;
            end
         end
         S_DONE:
         begin
            s_d.control_status_register[dsd_pkg::CSR_RDY_BIT] = 1'b1;
            s_d.st = S_IDLE;
         end
         default: s_d.st = S_IDLE;
      endcase
   end
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         s_q <= '0;
         s_q.st <= S_IDLE;
         s_q.control_status_register <= dsd_pkg::CSR_RESET;
      end
      else
      begin
         s_q <= s_d;
      end
      if (bufWe)
      begin
         buffer[s_q.ptr[7:0]] <= bufWdata;
      end
      if (siloLoad)
      begin
         for (int i = 0; i < dsd_pkg::SILO_WORDS; i++)
         begin
            silo[i] <= 16'h0000;
         end
         silo[0] <= fn == dsd_pkg::FN_RDHDR ? logCylTrk : s_q.control_status_register;
         silo[1] <= s_q.ba;
         silo[2] <= s_q.da;
         silo[3] <= s_q.wc;
         silo[dsd_pkg::SILO_CYL_IDX] <= physCyl;
         silo[dsd_pkg::SILO_TRK_IDX] <= physTrk;
         silo[dsd_pkg::SILO_SEC_IDX] <= physSec;
      end
   end
endmodule // dsd_device

//--- core/dsd_host.sv
/*
 host end: drives register writes from a user command port and serves dma from memory.
 assumes the device end of dsd_link_if.
*/
`timescale 1ns/10ps
module dsd_host #(parameter int MEM_WORDS = 1024)
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   dsd_link_if.host link,
   input wire logic cmdValid,
   input wire logic [1:0] cmdAddr,
   input wire logic cmdWrite,
   input wire logic [15:0] cmdData,
   output logic [15:0] rdData,
   output logic irqSeen
);
   typedef struct packed
   {
      logic [15:0] rd;
      logic irq;
      logic [15:0] dmaRd;
   } dsd_host_t;
   dsd_host_t s_q, s_d;
   logic [15:0] mem [MEM_WORDS];
   logic [$clog2(MEM_WORDS)-1:0] idx;
   assign idx = link.dmaAddr[$clog2(MEM_WORDS):1];
   // loads follow address, disk position, count, then command
   assign link.regWr = cmdValid && cmdWrite;
   assign link.regRd = cmdValid && !cmdWrite;
   assign link.regAddr = cmdAddr;
   assign link.regWdata = cmdData;
   assign link.dmaAck = link.dmaReq;
   assign link.dmaRdata = s_q.dmaRd;
   assign rdData = s_q.rd;
   assign irqSeen = s_q.irq;
   always_comb
   begin
      s_d = s_q;
      s_d.dmaRd = mem[idx];
      s_d.irq = link.irqReq;
      if (link.regRd)
      begin
         s_d.rd = link.regRdata;
      end
   end
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
      if (link.dmaReq && link.dmaWrite)
      begin
         mem[idx] <= link.dmaWdata;
      end
   end
endmodule // dsd_host

//--- tb/dsd_link_monitor.sv
/*
 checker for the sector transfer link, fed with the link signals as plain inputs.
 assumes both ends share clk_sys and the synchronous active-high sys_rst.
*/
`timescale 1ns/10ps
module dsd_link_monitor
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [15:0] regWdata,
   input wire logic [1:0] regAddr,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [15:0] regRdata,
   input wire logic irqReq,
   input wire logic [8:0] irqVector,
   input wire logic [2:0] irqLevel,
   input wire logic dmaReq,
   input wire logic dmaAck,
   input wire logic [15:0] dmaAddr
);
   // ----------------------------------------
   // helper state
   // ----------------------------------------
   // high from initialize until the first control write, so the reset view can be checked
   logic fresh_q;
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         fresh_q <= 1'b1;
      else if (regWr && regAddr == 2'h0)
         fresh_q <= 1'b0;
   end
   default clocking cbMon @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   AST_IRQ_CODE: assert property (irqReq |-> irqVector == 9'h070 && irqLevel == 3'h5)
      else $error("interrupt vector or level wrong");
   AST_RST_VIEW: assert property (regRd && regAddr == 2'h0 && fresh_q |-> regRdata[7:6] == 2'h2)
      else $error("control word after initialize wrong");
   AST_GO_DROP: assert property (regWr && regAddr == 2'h0 && !regWdata[7] |=> !irqReq)
      else $error("interrupt kept after start of function");
   AST_IE_OFF: assert property (regWr && regAddr == 2'h0 && !regWdata[6] |=> !irqReq)
      else $error("interrupt kept with enable cleared");
   AST_SEEK_IRQ: assert property (regWr && regAddr == 2'h0 && regWdata[7:1] == 7'h23 |-> ##[1:4] irqReq)
      else $error("seek did not interrupt at once");
   AST_IRQ_HOLD: assert property (irqReq && !(regWr && regAddr == 2'h0) |=> irqReq)
      else $error("interrupt dropped while enable and ready stand");
   AST_DMA_ACK: assert property (dmaReq |-> dmaAck)
      else $error("dma request not acknowledged");
   AST_DMA_STEP: assert property (dmaReq ##1 dmaReq |-> dmaAddr == $past(dmaAddr) + 16'h0002)
      else $error("dma address did not step one word");
endmodule // dsd_link_monitor

//--- tb/tb_disk_sector_dma_control.sv
/*
 self-checking bench: host end and device end joined by dsd_link_if, disk side driven here.
 assumes the core/ package, interface and modules are compiled first.
*/
`timescale 1ns/10ps
module tb_disk_sector_dma_control;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic cmdValid = 1'b0;
   logic [1:0] cmdAddr = 2'h0;
   logic cmdWrite = 1'b0;
   logic [15:0] cmdData = 16'h0000;
   logic diskValid = 1'b0;
   logic [15:0] diskRdata = 16'h0000;
   logic [15:0] logCylTrk = 16'h0280;
   logic [15:0] physCyl = 16'h0123;
   logic [15:0] physTrk = 16'h0004;
   logic [15:0] physSec = 16'h0011;
   logic replaceTrack = 1'b0;
   logic driveReady = 1'b1;
   logic [15:0] rdData, diskWdata, replaceWord;
   logic [31:0] eccOut;
   logic irqSeen, diskReadReq, diskWriteStb, replaceStb;
   int n_fail = 0;
   int compares = 0;
   int cyc = 0;
   int nStb, nDma, nDisk, dmaAtStb, padBad, dataBad, earlyDma, rdReq;
   // ----------------------------------------
   // structure
   // ----------------------------------------
   dsd_link_if link ();
   dsd_device #(.FIFO_DEPTH(8)) u_dsd_device (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link),
      .logCylTrk(logCylTrk), .physCyl(physCyl), .physTrk(physTrk), .physSec(physSec),
      .diskValid(diskValid), .diskRdata(diskRdata), .diskEccBad(1'b0),
      .diskBurstMask(16'h0000), .diskBurstIdx(8'h00), .diskReadReq(diskReadReq),
      .diskWriteStb(diskWriteStb), .diskWdata(diskWdata), .eccOut(eccOut),
      .replaceStb(replaceStb), .replaceWord(replaceWord), .replaceTrack(replaceTrack),
      .driveReady(driveReady));
   dsd_host #(.MEM_WORDS(1024)) u_dsd_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link),
      .cmdValid(cmdValid), .cmdAddr(cmdAddr), .cmdWrite(cmdWrite), .cmdData(cmdData),
      .rdData(rdData), .irqSeen(irqSeen));
   dsd_link_monitor u_dsd_link_monitor (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .regWdata(link.regWdata), .regAddr(link.regAddr), .regWr(link.regWr), .regRd(link.regRd),
      .regRdata(link.regRdata), .irqReq(link.irqReq), .irqVector(link.irqVector),
      .irqLevel(link.irqLevel), .dmaReq(link.dmaReq), .dmaAck(link.dmaAck),
      .dmaAddr(link.dmaAddr));
   always #2.5 clk_sys = ~clk_sys;
   // ----------------------------------------
   // watchers and helpers
   // ----------------------------------------
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         n_fail++;
         $display("[ERR] run too long");
         end_of_test();
      end
      rdReq += int'(diskReadReq === 1'b1);
      if (diskWriteStb === 1'b1)
      begin
         if (nStb == 0)
            dmaAtStb = nDma;
         if (nStb >= 4 && diskWdata !== 16'h0000)
            padBad = 1;
         nStb++;
      end
      if (link.dmaReq === 1'b1 && link.dmaAck === 1'b1)
      begin
         // reads hand words to memory in disk order, so the pattern index is the dma count
         if (link.dmaWrite === 1'b1 && nDisk < 256)
            earlyDma = 1;
         if (link.dmaWrite === 1'b1 && link.dmaWdata !== {8'hA5, nDma[7:0]})
            dataBad = 1;
         nDma++;
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic hostOp(input logic [1:0] a, input logic w, input logic [15:0] d);
      cmdValid <= 1'b1;
      cmdAddr <= a;
      cmdWrite <= w;
      cmdData <= d;
      @(posedge clk_sys);
      cmdValid <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic clearCounts();
      nStb = 0;
      nDma = 0;
      nDisk = 0;
      dmaAtStb = -1;
      padBad = 0;
      dataBad = 0;
      earlyDma = 0;
      rdReq = 0;
   endtask
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic testReset();
      hostOp(2'h0, 1'b0, 16'h0000);
      check("csr ready and enable", rdData & 16'h00C0, 16'h0080);
      check("drive ready shown", rdData & 16'h0100, 16'h0100);
      driveReady <= 1'b0;
      hostOp(2'h0, 1'b0, 16'h0000);
      check("drive not ready shown", rdData & 16'h0180, 16'h0080);
      driveReady <= 1'b1;
      $display("test reset done");
   endtask
   task automatic testSeek();
      hostOp(2'h0, 1'b1, 16'h0046);
      for (int i = 0; i < 50 && irqSeen !== 1'b1; i++) @(posedge clk_sys);
      check("seek interrupt", {15'h0000, irqSeen}, 16'h0001);
      check("vector", {7'h00, link.irqVector}, 16'h0070);
      check("level", {13'h0000, link.irqLevel}, 16'h0005);
      hostOp(2'h0, 1'b1, 16'h0080);
      check("irq after enable off", {15'h0000, link.irqReq}, 16'h0000);
      $display("test seek done");
   endtask
   task automatic testReplace();
      logic [15:0] exp;
      replaceTrack <= 1'b1;
      for (int k = 0; k < 5; k++)
      begin
         @(negedge clk_sys);
         case (k % 4)
            0: exp = physCyl;
            1: exp = {physTrk[7:0], 8'hB4};
            2: exp = eccOut[31:16];
            default: exp = eccOut[15:0];
         endcase
         check("replace strobe", {15'h0000, replaceStb}, 16'h0001);
         check("replace word", replaceWord, exp);
      end
      @(posedge clk_sys);
      replaceTrack <= 1'b0;
      repeat (4) @(posedge clk_sys);
      $display("test replace done");
   endtask
   task automatic testShortWrite();
      hostOp(2'h1, 1'b1, 16'h0100);
      hostOp(2'h2, 1'b1, 16'h0000);
      hostOp(2'h3, 1'b1, 16'hFFFC);
      clearCounts();
      hostOp(2'h0, 1'b1, 16'h000A);
      for (int i = 0; i < 3000 && nStb < 256; i++) @(posedge clk_sys);
      repeat (20) @(posedge clk_sys);
      check("field words", 16'(nStb), 16'h0100);
      check("zero padding", 16'(padBad), 16'h0000);
      check("dma words", 16'(nDma), 16'h0004);
      check("dma before disk", 16'(dmaAtStb), 16'h0004);
      hostOp(2'h1, 1'b0, 16'h0000);
      check("address after", rdData, 16'h0108);
      $display("test short write done");
   endtask
   task automatic testRead(input logic [15:0] cmd);
      hostOp(2'h1, 1'b1, 16'h0200);
      hostOp(2'h2, 1'b1, 16'h0001);
      hostOp(2'h3, 1'b1, 16'hFF00);
      clearCounts();
      hostOp(2'h0, 1'b1, cmd);
      for (int i = 0; i < 200 && rdReq == 0; i++) @(posedge clk_sys);
      for (int i = 0; i < 256; i++)
      begin
         diskValid <= 1'b1;
         diskRdata <= {8'hA5, 8'(i)};
         @(posedge clk_sys);
         nDisk = i + 1;
      end
      diskValid <= 1'b0;
      for (int i = 0; i < 3000 && nDma < 256; i++) @(posedge clk_sys);
      repeat (20) @(posedge clk_sys);
      check("read dma words", 16'(nDma), 16'h0100);
      check("dma before full sector", 16'(earlyDma), 16'h0000);
      check("read data", 16'(dataBad), 16'h0000);
      $display("test read done");
   endtask
   task automatic testSilo();
      hostOp(2'h0, 1'b1, 16'h0000);
      repeat (20) @(posedge clk_sys);
      for (int i = 0; i < 121; i++)
      begin
         hostOp(2'h3, 1'b0, 16'h0000);
         if (i == 118)
            check("silo cylinder", rdData, physCyl);
         if (i == 119)
            check("silo track", rdData, physTrk);
         if (i == 120)
            check("silo sector", rdData, physSec);
      end
      hostOp(2'h0, 1'b1, 16'h0008);
      repeat (20) @(posedge clk_sys);
      hostOp(2'h3, 1'b0, 16'h0000);
      check("read header word", rdData, logCylTrk);
      $display("test silo done");
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      clearCounts();
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      testReset();
      testSeek();
      testReplace();
      testShortWrite();
      testRead(16'h000C);
      testRead(16'h000E);
      testSilo();
      end_of_test();
   end
endmodule // tb_disk_sector_dma_control
